// ===== common/wis_cfg.svh
`ifndef WIS_CFG_SVH
`define WIS_CFG_SVH
// Clock and nonvolatile memory ready wait
`define WIS_CLK_MHZ 20
`define WIS_NVM_WAIT_NS 10000
`define WIS_NVM_WAIT_CYC ((`WIS_NVM_WAIT_NS * `WIS_CLK_MHZ + 999) / 1000)
// Wake tone length and supply shutdown delay (cycles)
`define WIS_TONE_CYC 16'h0190
`define WIS_SUPPLY_SD_CYC 16'h03E8
// Device setup field positions
`define WIS_SETUP_ADDR_SEL 0
`define WIS_SETUP_REG_DIS 1
`define WIS_ADDR_W 5
`endif

// ===== common/wis_pkg.sv
package wis_pkg;
  // Sequencer states, one-hot
  typedef enum logic [10:0] {
    WIS_SHUTDOWN = 11'h001,
    WIS_NVM_WAIT = 11'h002,
    WIS_NVM_LOAD = 11'h004,
    WIS_ANA_COPY = 11'h008,
    WIS_ADDR_SMP = 11'h010,
    WIS_TEMP_SMP = 11'h020,
    WIS_CLR_MASK = 11'h040,
    WIS_UART_ON = 11'h080,
    WIS_TONE_END = 11'h100,
    WIS_DIFF_ON = 11'h200,
    WIS_IDLE = 11'h400
  } wis_state_t;
  // Status carried out together
  typedef struct packed {
    logic init_in_progress_flag;
    logic uart_enabled;
    logic diff_enabled;
    logic analog_faults_enabled;
    logic reset_occurred_fault;
  } wis_status_t;
endpackage

// ===== hw/wis_sequencer.sv
`timescale 1ns/10ps
`include "wis_cfg.svh"
// Notes on behaviour
// - Wake pin high or low-side tone leaves shutdown for the init run.
// - Wake pin is a level; high in shutdown wakes at any stack position.
// - Power-down with wake pin high wakes again at once.
// - On waking, send a wake tone on the high-side link.
// - In shutdown the low-side link only receives; nothing transmitted.
// - Regulator driving but supply low past the delay enters shutdown.
// - Wakeup resets the sequencer, loads NVM registers, defaults others.
// - After reset, voltage/aux/reference fault flags read 0 until sampled.
// - Same sequence for power-on, soft reset and received wake tone.
// - Sequencer starts with the oscillator and starts the tone at once.
// - Wait about 10 us for the NVM, then load the device setup register.
// - Copy configuration to analog die, except regulator power-down.
// - Address select 0 samples five pins into the node identifier.
// - Only digital-die temperature sampled; no unsampled channel faults.
// - Clear masked faults, then start UART monitoring.
// - In parallel wait no supply fault or host abort; enable, clear flag.
// - Differential link monitored only after the outgoing tone ends.
// - After host clears reset fault, drop regulator if disable bit set.
// - Init flag is 1 while initialization runs; abort may give bad faults.
// - Power-down request enters shutdown if wake pin stays low.
// - No valid frame within the timeout period enters shutdown.
module wis_sequencer
  import wis_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Wake sources and shutdown causes
  input wire logic wake_request_pin,
  input wire logic low_side_tone_detect,
  input wire logic soft_reset_request,
  input wire logic power_down_request,
  input wire logic comm_timeout_expired,
  input wire logic valid_frame_seen,
  // Supplies and analog die
  input wire logic regulated_supply_ok,
  input wire logic monitor_supply_fault,
  // NVM interface
  input wire logic [7:0] nvm_setup_data,
  // Pins and host controls
  input wire logic [4:0] gpio_addr_pins,
  input wire logic host_abort_init,
  input wire logic host_clear_reset_fault,
  input wire logic sample_all_done,
  input wire logic host_byte_valid,
  input wire logic [7:0] host_byte,
  // Link and regulator outputs
  output logic high_side_tone,
  output logic low_side_tx_enable,
  output logic regulator_drive,
  output logic [7:0] device_setup_reg,
  output logic [7:0] analog_setup_reg,
  output logic [4:0] node_identifier_reg,
  output logic temp_sample_strobe,
  output logic clear_masked_faults,
  output logic fault_flags_valid,
  output logic host_byte_accept,
  output logic [7:0] host_byte_out,
  output wis_status_t status
);

  ////////////////////////////////////////////////////////////////////////////
  wis_state_t state_reg, state_next;
  logic [15:0] tone_cnt_reg;
  logic [15:0] wait_cnt_reg;
  logic [15:0] sd_cnt_reg;
  logic tone_busy_reg;
  logic shutdown_req;
  logic wake_req;
  logic init_flag_reg;
  logic uart_en_reg;
  logic diff_en_reg;
  logic ana_en_reg;
  logic rst_fault_reg;

  // Status word gathered from its own flops, one driver per field
  assign status = {init_flag_reg, uart_en_reg, diff_en_reg, ana_en_reg,
    rst_fault_reg};

  // Saturating decrement used by the timers
  function automatic logic [15:0] dec_sat(input logic [15:0] v);
    dec_sat = (v == 16'h0000) ? 16'h0000 : v - 16'h0001;
  endfunction

  assign wake_req = wake_request_pin | low_side_tone_detect;
  // shutdown causes, power-down, comm timeout, supply low past delay
  // a power-down with the wake pin high becomes a restart below
  assign shutdown_req = power_down_request
    | (comm_timeout_expired & ~valid_frame_seen)
    | (regulator_drive & ~regulated_supply_ok & sd_cnt_reg == 16'h0000);

  ////////////////////////////////////////////////////////////////////////////
  // Next state of the sequencer
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      WIS_SHUTDOWN: begin
        if (wake_req) begin
          state_next = WIS_NVM_WAIT;
        end
      end
      WIS_NVM_WAIT: begin
        if (wait_cnt_reg == 16'h0000) begin
          state_next = WIS_NVM_LOAD;
        end
      end
      WIS_NVM_LOAD: state_next = WIS_ANA_COPY;
      WIS_ANA_COPY: state_next = WIS_ADDR_SMP;
      WIS_ADDR_SMP: state_next = WIS_TEMP_SMP;
      WIS_TEMP_SMP: state_next = WIS_CLR_MASK;
      WIS_CLR_MASK: state_next = WIS_UART_ON;
      WIS_UART_ON: state_next = WIS_TONE_END;
      WIS_TONE_END: begin
        if (!tone_busy_reg) begin
          state_next = WIS_DIFF_ON;
        end
      end
      WIS_DIFF_ON: state_next = WIS_IDLE;
      WIS_IDLE: state_next = WIS_IDLE;
      default: state_next = WIS_SHUTDOWN;
    endcase
    // wake pin high re-wakes; same run for every reset source
    if (state_reg != WIS_SHUTDOWN) begin
      if (shutdown_req) begin
        state_next = wake_request_pin ? WIS_NVM_WAIT : WIS_SHUTDOWN;
      end else if (soft_reset_request
          || (low_side_tone_detect && state_reg == WIS_IDLE)) begin
        state_next = WIS_NVM_WAIT;
      end
    end
  end

  // state register, restarts fully on wake
  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg <= WIS_NVM_WAIT;
    end else begin
      state_reg <= state_next;
    end
  end

  // NVM wait counter, reloaded on every entry
  always_ff @(posedge clk) begin
    if (srst) begin
      wait_cnt_reg <= 16'(`WIS_NVM_WAIT_CYC);
    end else if (state_next == WIS_NVM_WAIT && state_reg != WIS_NVM_WAIT) begin
      wait_cnt_reg <= 16'(`WIS_NVM_WAIT_CYC);
    end else begin
      wait_cnt_reg <= dec_sat(wait_cnt_reg);
    end
  end

  // Supply shutdown delay counter
  always_ff @(posedge clk) begin
    if (srst || regulated_supply_ok || !regulator_drive) begin
      sd_cnt_reg <= `WIS_SUPPLY_SD_CYC;
    end else begin
      sd_cnt_reg <= dec_sat(sd_cnt_reg);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // wake tone starts with the sequencer
  always_ff @(posedge clk) begin
    if (srst) begin
      tone_cnt_reg <= `WIS_TONE_CYC;
      tone_busy_reg <= 1'b1;
    end else if (state_next == WIS_NVM_WAIT && state_reg != WIS_NVM_WAIT) begin
      tone_cnt_reg <= `WIS_TONE_CYC;
      tone_busy_reg <= 1'b1;
    end else if (state_reg == WIS_SHUTDOWN) begin
      tone_busy_reg <= 1'b0;
    end else begin
      tone_cnt_reg <= dec_sat(tone_cnt_reg);
      tone_busy_reg <= (tone_cnt_reg > 16'h0001);
    end
  end

  // Tone output and low-side transmitter
  always_ff @(posedge clk) begin
    if (srst) begin
      high_side_tone <= 1'b0;
      low_side_tx_enable <= 1'b0;
    end else begin
      high_side_tone <= tone_busy_reg && state_next != WIS_SHUTDOWN;
      low_side_tx_enable <= state_next == WIS_DIFF_ON
        || (low_side_tx_enable && state_next == WIS_IDLE);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // NVM load, analog copy, address sample
  always_ff @(posedge clk) begin
    if (srst) begin
      device_setup_reg <= 8'h00;
      analog_setup_reg <= 8'h00;
      node_identifier_reg <= 5'h00;
    end else begin
      // Defaults in shutdown and on every restart, before the reload
      if (state_reg == WIS_SHUTDOWN || state_reg == WIS_NVM_WAIT) begin
        device_setup_reg <= 8'h00;
        analog_setup_reg <= 8'h00;
        node_identifier_reg <= 5'h00;
      end
      if (state_reg == WIS_NVM_LOAD) begin
        device_setup_reg <= nvm_setup_data;
      end
      if (state_reg == WIS_ANA_COPY) begin
        // Regulator disable bit left out of the analog copy
        analog_setup_reg <= device_setup_reg
          & ~(8'h01 << `WIS_SETUP_REG_DIS);
      end
      if (state_reg == WIS_ADDR_SMP
          && !device_setup_reg[`WIS_SETUP_ADDR_SEL]) begin
        node_identifier_reg <= gpio_addr_pins;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      temp_sample_strobe <= 1'b0;
      clear_masked_faults <= 1'b0;
    end else begin
      temp_sample_strobe <= state_next == WIS_TEMP_SMP;
      clear_masked_faults <= state_next == WIS_CLR_MASK;
    end
  end

  // fault flags invalid until a sample-all runs
  always_ff @(posedge clk) begin
    if (srst || state_reg == WIS_NVM_WAIT) begin
      fault_flags_valid <= 1'b0;
    end else if (sample_all_done) begin
      fault_flags_valid <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // UART monitoring and differential monitoring enables
  always_ff @(posedge clk) begin
    if (srst || state_next == WIS_NVM_WAIT || state_next == WIS_SHUTDOWN) begin
      uart_en_reg <= 1'b0;
      diff_en_reg <= 1'b0;
    end else begin
      if (state_reg == WIS_UART_ON) begin
        uart_en_reg <= 1'b1;
      end
      if (state_reg == WIS_DIFF_ON) begin
        diff_en_reg <= 1'b1;
      end
    end
  end

  // host bytes pass only once UART monitoring is on
  always_ff @(posedge clk) begin
    if (srst) begin
      host_byte_accept <= 1'b0;
      host_byte_out <= 8'h00;
    end else begin
      host_byte_accept <= host_byte_valid && uart_en_reg;
      host_byte_out <= host_byte;
    end
  end

  // parallel analog fault enable and init flag
  always_ff @(posedge clk) begin
    if (srst || state_next == WIS_NVM_WAIT) begin
      init_flag_reg <= 1'b1;
      ana_en_reg <= 1'b0;
    end else if (state_reg == WIS_SHUTDOWN) begin
      init_flag_reg <= 1'b0;
      ana_en_reg <= 1'b0;
    end else if (init_flag_reg && state_reg != WIS_NVM_WAIT
        && (!monitor_supply_fault || host_abort_init)) begin
      init_flag_reg <= 1'b0;
      ana_en_reg <= 1'b1;
    end
  end

  // reset fault set on wake; set wins over host clear
  always_ff @(posedge clk) begin
    if (srst || state_next == WIS_NVM_WAIT) begin
      rst_fault_reg <= 1'b1;
    end else if (host_clear_reset_fault) begin
      rst_fault_reg <= 1'b0;
    end
  end

  // regulator off after reset fault clears with disable set
  always_ff @(posedge clk) begin
    if (srst) begin
      regulator_drive <= 1'b1;
    end else if (state_next == WIS_SHUTDOWN) begin
      regulator_drive <= 1'b0;
    end else if (state_next == WIS_NVM_WAIT) begin
      regulator_drive <= 1'b1;
    end else if (!rst_fault_reg && state_reg == WIS_IDLE
        && device_setup_reg[`WIS_SETUP_REG_DIS]) begin
      regulator_drive <= 1'b0;
    end
  end

endmodule

// ===== tb/wis_seq_sva.sv
`timescale 1ns/10ps
`include "wis_cfg.svh"
module wis_seq_sva
  import wis_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Restart causes and host input
  input wire logic soft_reset_request,
  input wire logic low_side_tone_detect,
  input wire logic host_byte_valid,
  input wire logic [7:0] host_byte,
  // Sequencer outputs
  input wire logic high_side_tone,
  input wire logic [7:0] analog_setup_reg,
  input wire logic temp_sample_strobe,
  input wire logic clear_masked_faults,
  input wire logic host_byte_accept,
  input wire logic [7:0] host_byte_out,
  input wire wis_status_t status
);
  logic [15:0] since_reg;
  logic [15:0] tone_len_reg;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  ////////////////
  // Cycles since the last srst, soft reset request or low-side tone detect
  always_ff @(posedge clk) begin
    if (srst || soft_reset_request || low_side_tone_detect) begin
      since_reg <= 16'h0000;
    end else if (since_reg != 16'hffff) begin
      since_reg <= since_reg + 16'h0001;
    end
  end
  // Length of the outgoing tone so far
  always_ff @(posedge clk) begin
    if (srst || !high_side_tone) begin
      tone_len_reg <= 16'h0000;
    end else begin
      tone_len_reg <= tone_len_reg + 16'h0001;
    end
  end
  ////////////////
  // Late steps of the init run
  sequence s_clear_uart;
    clear_masked_faults ##[1:2] status.uart_enabled;
  endsequence
  sequence s_tone_end;
    $fell(high_side_tone);
  endsequence
  ////////////////
  chk_nvm_settle: assert property (
    temp_sample_strobe |-> since_reg >= 16'h00c8)
    else $error("temperature sampled early");
  chk_init_order: assert property (
    $fell(srst) |-> ##[200:215] temp_sample_strobe)
    else $error("init run stalled");
  chk_clear_uart: assert property (
    temp_sample_strobe |=> s_clear_uart)
    else $error("clear or uart step missing");
  chk_tone_len: assert property (
    s_tone_end |-> tone_len_reg == `WIS_TONE_CYC)
    else $error("tone length wrong");
  chk_diff_late: assert property (
    $rose(status.diff_enabled) |-> !high_side_tone)
    else $error("diff link on during tone");
  chk_flag_clear: assert property (
    $rose(status.analog_faults_enabled)
      |-> ##[0:1] !status.init_in_progress_flag)
    else $error("init flag left set");
  chk_analog_mask: assert property (
    analog_setup_reg[`WIS_SETUP_REG_DIS] == 1'b0)
    else $error("regulator setting copied");
  chk_byte_gate: assert property (
    host_byte_accept |-> $past(status.uart_enabled) && $past(host_byte_valid)
      && host_byte_out == $past(host_byte))
    else $error("host byte passed wrongly");
endmodule
bind wis_sequencer wis_seq_sva i_sva (.*);

// ===== tb/wis_supply_model.sv
`timescale 1ns/10ps
module wis_supply_model #(
  parameter int RAMP_CYC = 20,
  parameter int VM_CYC = 300
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Regulator drive and forced sag
  input wire logic regulator_drive,
  input wire logic supply_sag,
  // Supply status to the device
  output logic regulated_supply_ok,
  output logic monitor_supply_fault
);
  int ramp_reg;
  // Supply ramps only while the regulator drives
  always_ff @(posedge clk) begin
    if (srst || supply_sag) begin
      ramp_reg <= 0;
    end else if (regulator_drive && ramp_reg < VM_CYC) begin
      ramp_reg <= ramp_reg + 1;
    end
  end
  assign regulated_supply_ok = ramp_reg >= RAMP_CYC;
  assign monitor_supply_fault = ramp_reg < VM_CYC;
endmodule

// ===== tb/tb.sv
`timescale 1ns/10ps
module tb;
  import wis_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic wake_request_pin = 1'b0;
  logic valid_frame_seen = 1'b0;
  logic supply_sag = 1'b0;
  logic host_byte_valid = 1'b0;
  logic [7:0] host_byte = 8'h00;
  logic [7:0] nvm_setup_data = 8'h00;
  logic [4:0] gpio_addr_pins = 5'h15;
  logic [6:0] pulse_vec = 7'h00;
  logic regulated_supply_ok, monitor_supply_fault, high_side_tone;
  logic low_side_tx_enable, regulator_drive, temp_sample_strobe;
  logic clear_masked_faults, fault_flags_valid, host_byte_accept;
  logic [7:0] device_setup_reg, analog_setup_reg, host_byte_out;
  logic [4:0] node_identifier_reg;
  wis_status_t status;
  int bad_count = 0;
  int checks_done = 0;
  // One-cycle request pulses
  wire soft_reset_request = pulse_vec[0];
  wire power_down_request = pulse_vec[1];
  wire comm_timeout_expired = pulse_vec[2];
  wire low_side_tone_detect = pulse_vec[3];
  wire host_abort_init = pulse_vec[4];
  wire host_clear_reset_fault = pulse_vec[5];
  wire sample_all_done = pulse_vec[6];
  wis_sequencer i_dut (.*);
  wis_supply_model i_supply (.*);
  always #25 clk = ~clk;
  ////////////////
  task check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task kick(input int k);
    @(posedge clk);
    pulse_vec <= 7'h01 << k;
    @(posedge clk);
    pulse_vec <= 7'h00;
  endtask
  // host sends one byte before it polls for readiness, then talks again
  // Bounded wait for the tone (0) or full readiness (1)
  task wait_for(input int sel, input int lim);
    int n;
    n = 0;
    while (!(sel ? status.diff_enabled : high_side_tone) && n < lim) begin
      @(posedge clk);
      n++;
    end
    check(8'(sel ? status.diff_enabled : high_side_tone), 8'h01);
  endtask
  task send_byte(input logic [7:0] b, input logic exp);
    @(posedge clk);
    host_byte_valid <= 1'b1;
    host_byte <= b;
    @(posedge clk);
    host_byte_valid <= 1'b0;
    @(posedge clk);
    check(8'(host_byte_accept), 8'(exp));
    if (exp) check(host_byte_out, b);
  endtask
  task finish_test();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  ////////////////
  // Main sequence
  initial begin
    tick(3);
    srst <= 1'b0;
    tick(5);
    check(8'(status.init_in_progress_flag), 8'h01);
    send_byte(8'h5a, 1'b0);
    wait_for(1, 1000);
    check(8'(node_identifier_reg), 8'h15);
    check(8'(status), 8'h0f);
    check(8'(fault_flags_valid), 8'h00);
    check(8'(low_side_tx_enable), 8'h01);
    send_byte(8'ha5, 1'b1);
    kick(6);
    tick(2);
    check(8'(fault_flags_valid), 8'h01);
    $display("test power_on done");
    nvm_setup_data <= 8'h03;
    gpio_addr_pins <= 5'h0a;
    kick(0);
    tick(3);
    check(8'(status.init_in_progress_flag), 8'h01);
    wait_for(1, 1000);
    check(device_setup_reg, 8'h03);
    check(analog_setup_reg, 8'h01);
    check(8'(node_identifier_reg), 8'h00);
    check(8'(regulator_drive), 8'h01);
    kick(5);
    tick(3);
    check(8'(regulator_drive), 8'h00);
    $display("test soft_reset done");
    kick(1);
    tick(50);
    check(8'({status.uart_enabled, low_side_tx_enable}), 8'h00);
    check(8'(high_side_tone), 8'h00);
    wake_request_pin <= 1'b1;
    wait_for(0, 20);
    wait_for(1, 1000);
    kick(1);
    tick(3);
    check(8'(status.init_in_progress_flag), 8'h01);
    wait_for(1, 1000);
    wake_request_pin <= 1'b0;
    $display("test wake_pin done");
    valid_frame_seen <= 1'b1;
    kick(2);
    tick(3);
    check(8'(status.uart_enabled), 8'h01);
    valid_frame_seen <= 1'b0;
    kick(2);
    tick(3);
    check(8'(status.uart_enabled), 8'h00);
    kick(3);
    wait_for(0, 20);
    wait_for(1, 1000);
    $display("test timeout done");
    supply_sag <= 1'b1;
    tick(900);
    check(8'(status.uart_enabled), 8'h01);
    tick(200);
    check(8'(status.uart_enabled), 8'h00);
    supply_sag <= 1'b0;
    wake_request_pin <= 1'b1;
    wait_for(0, 20);
    tick(215);
    check(8'(status.init_in_progress_flag), 8'h01);
    kick(4);
    tick(3);
    check(8'(status.init_in_progress_flag), 8'h00);
    wait_for(1, 1000);
    wake_request_pin <= 1'b0;
    $display("test supply done");
    finish_test();
  end
  // Watchdog well beyond the expected run of about 3600 cycles
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    finish_test();
  end
endmodule
